// ===== hdl/dmd_core.sv
// Serial instruction receiver, display memories and digit scanner of a dot
// matrix LCD controller. Assumes the serial pins are asynchronous to i_clk and
// that the host spaces instructions well beyond the execution time.
//
// Summary of operation
// [RULE1] Character code RAM of 52 bytes.
// [RULE2] Digits 1 to 13 show addresses 00 to 0C.
// [RULE3] Main shift left adds one, right wraps back.
// [RULE4] Character address is six bits, LSB first.
// [RULE5] Symbol RAM 13 by 5 drives dots directly.
// [RULE6] Symbol digits map 0 to C, rotate on shift.
// [RULE7] Symbol address is four bits, LSB first.
// [RULE8] Glyph ROM of 240 patterns by code.
// [RULE9] Writable glyph RAM of 16 patterns.
// [RULE10] Codes outside ROM select a glyph RAM slot.
// [RULE11] Sample on clock rise, act on enable fall.
// [RULE12] Eight address bits then 64 instruction bits.
// [RULE13] Host spaces transfers beyond execution time.
// [RULE14] Memory and shift take 27 us; setup immediate.
// [RULE15] On/off immediate, 27 us when entering sleep.
// [RULE16] Duty setup opcode carries duty and frame select.
// [RULE17] Duty select sets 1/8, 1/9, 1/10 commons.
// [RULE18] Frame divisor 3072, 3456, 3840, halved on select.
// [RULE19] On/off carries digit enables, main, symbol, blank, sleep.
// [RULE20] Main and symbol enables gate enabled digits.
// [RULE21] Output blank holds outputs at lowest level.
// [RULE22] Shift moves main, symbol per enables and direction.
// [RULE23] Set pointer loads both addresses together.
// [RULE24] Character write carries code, address, increment flag.
// [RULE25] Symbol write carries dots, address, increment flag.
// [RULE26] Glyph write carries 45 bits and slot code.
// [RULE27] Contrast carries level and enable.
// [RULE28] Port setting carries scan lines, levels, roles.
`timescale 1ns/1ps
`include "dmd_defs.svh"

module dmd_core #(
  parameter logic [7:0] BUS_ADDR = 8'h5A  // Arbitrary device select value.
) (
  // Clock and reset.
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // Serial pins from the host.
  input  wire logic        i_shift_clock_pin,
  input  wire logic        i_serial_data_pin,
  input  wire logic        i_chip_enable_pin,
  // Status.
  output logic             o_busy,
  output logic             o_sleep_select,
  // Display technique.
  output logic [1:0]       o_duty_select,
  output logic             o_frame_rate_select,
  output logic             o_com9_en,
  output logic             o_com10_en,
  output logic             o_frame_tick,
  output logic             o_output_blank,
  // Contrast and ports.
  output logic [3:0]       o_contrast_level,
  output logic             o_contrast_enable,
  output logic [5:0]       o_scan_line_setting,
  output logic [1:0]       o_output_port_level,
  output logic [1:0]       o_port_role_select,
  // Digit scan.
  output logic             o_scan_valid,
  output logic [3:0]       o_scan_digit,
  output logic [44:0]      o_main_glyph_data,
  output logic [4:0]       o_symbol_dot_data
);

  ////////////////////////////////////////////////////////////////////////////////
  // Functions.
  function automatic dmd_pkg::dmd_char_addr_t add52(input dmd_pkg::dmd_char_addr_t a,
                                                     input dmd_pkg::dmd_char_addr_t b);
    logic [6:0] s;
    s = {1'b0, a} + {1'b0, b};
    if (s >= 7'(`DMD_CHAR_DEPTH)) begin
      s = s - 7'(`DMD_CHAR_DEPTH);
    end
    add52 = s[5:0];
  endfunction

  function automatic dmd_pkg::dmd_sym_addr_t add13(input dmd_pkg::dmd_sym_addr_t a,
                                                    input dmd_pkg::dmd_sym_addr_t b);
    logic [4:0] s;
    s = {1'b0, a} + {1'b0, b};
    if (s >= 5'(`DMD_SYM_DEPTH)) begin
      s = s - 5'(`DMD_SYM_DEPTH);
    end
    add13 = s[3:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.
  logic        sclk_s1_q, sclk_s2_q, sclk_s3_q;
  logic        ce_s1_q, ce_s2_q, ce_s3_q;
  logic        sd_s1_q, sd_s2_q;
  wire         sclk_rise = sclk_s2_q & ~sclk_s3_q;
  wire         ce_rise   = ce_s2_q & ~ce_s3_q;
  wire         ce_fall   = ~ce_s2_q & ce_s3_q;

  always_ff @(posedge i_clk) begin
    sclk_s1_q <= i_shift_clock_pin;
    sclk_s2_q <= sclk_s1_q;
    sclk_s3_q <= sclk_s2_q;
    ce_s1_q   <= i_chip_enable_pin;
    ce_s2_q   <= ce_s1_q;
    ce_s3_q   <= ce_s2_q;
    sd_s1_q   <= i_serial_data_pin;
    sd_s2_q   <= sd_s1_q;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Serial receiver. Only rising edges of the shift clock are used, so either idle level works.
  dmd_pkg::dmd_rx_state_t     rx_q;
  logic [7:0]                 addr_q;
  logic [`DMD_DATA_BITS-1:0]  data_q;
  logic [6:0]                 cnt_q;
  wire                        take_bit = sclk_rise & ce_s2_q & (rx_q == dmd_pkg::DMD_RX_DATA);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      addr_q <= '0;
    end else if (sclk_rise & ~ce_s2_q) begin
      addr_q <= {sd_s2_q, addr_q[7:1]};  // [RULE11] [RULE12]
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rx_q <= dmd_pkg::DMD_RX_ADDR;
      cnt_q <= '0;
    end else begin
      case (rx_q)
        dmd_pkg::DMD_RX_ADDR: begin
          if (ce_rise && addr_q == BUS_ADDR) begin
            rx_q  <= dmd_pkg::DMD_RX_DATA;  // [RULE12]
            cnt_q <= '0;
          end
        end
        dmd_pkg::DMD_RX_DATA: begin
          if (ce_fall) begin
            rx_q <= dmd_pkg::DMD_RX_ADDR;
          end else if (take_bit && cnt_q != 7'(`DMD_DATA_BITS)) begin
            cnt_q <= cnt_q + 7'd1;
          end
        end
        default: begin
          rx_q <= dmd_pkg::DMD_RX_ADDR;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      data_q <= '0;
    end else if (take_bit && cnt_q != 7'(`DMD_DATA_BITS)) begin
      data_q[cnt_q[5:0]] <= sd_s2_q;  // [RULE11] [RULE12]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Decode. An instruction runs at the fall of chip enable with all 64 bits in.
  logic        sleep_q;
  logic [9:0]  busy_q;
  wire  [3:0]  op       = {data_q[60], data_q[61], data_q[62], data_q[63]};
  wire         sleep_ok = (op == `DMD_OP_ONOFF) | (op == `DMD_OP_CONTRAST) | (op == `DMD_OP_PORT);
  wire         go       = ce_fall & (rx_q == dmd_pkg::DMD_RX_DATA) & (cnt_q == 7'(`DMD_DATA_BITS))
                          & (busy_q == '0) & (~sleep_q | sleep_ok);  // [RULE11] [RULE13]
  wire         do_tech  = go & (op == `DMD_OP_TECH);
  wire         do_onoff = go & (op == `DMD_OP_ONOFF);
  wire         do_shift = go & (op == `DMD_OP_SHIFT);
  wire         do_ptr   = go & (op == `DMD_OP_SETPTR);
  wire         do_charw = go & (op == `DMD_OP_CHARW);
  wire         do_symw  = go & (op == `DMD_OP_SYMW);
  wire         do_glyph = go & (op == `DMD_OP_GLYPHW);
  wire         do_con   = go & (op == `DMD_OP_CONTRAST);
  wire         do_port  = go & (op == `DMD_OP_PORT);
  wire         timed    = do_shift | do_ptr | do_charw | do_symw | do_glyph
                          | (do_onoff & data_q[`DMD_F_D]);  // [RULE14] [RULE15]
  wire  [5:0]  f_da     = data_q[`DMD_F_ADDR +: 6];  // [RULE4]
  wire  [3:0]  f_ra     = data_q[`DMD_F_ADDR +: 4];  // [RULE7]
  wire  [3:0]  f_ra_ptr = data_q[`DMD_F_M +: 4];

  // Execution time is only a guard window: effects land at once, new work is dropped.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      busy_q <= '0;
    end else if (timed) begin
      busy_q <= 10'(`DMD_EXEC_CYC - 1);  // [RULE14] [RULE15]
    end else if (busy_q != '0) begin
      busy_q <= busy_q - 10'd1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control state.
  logic [1:0]  duty_q;
  logic        frc_q, main_en_q, sym_en_q, blank_q;
  logic [12:0] digit_en_q;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      duty_q <= `DMD_RST_DUTY;
      frc_q  <= 1'b0;
    end else if (do_tech) begin
      duty_q <= {data_q[`DMD_F_M], data_q[`DMD_F_A]};  // [RULE16] [RULE17]
      frc_q  <= data_q[`DMD_F_C];  // [RULE16]
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      digit_en_q <= `DMD_RST_DIGITS;
      main_en_q  <= 1'b0;
      sym_en_q   <= 1'b0;
      blank_q    <= 1'b0;
      sleep_q    <= 1'b0;
    end else if (do_onoff) begin
      digit_en_q <= data_q[`DMD_F_LO +: `DMD_DIGITS];  // [RULE19]
      main_en_q  <= data_q[`DMD_F_M];
      sym_en_q   <= data_q[`DMD_F_A];
      blank_q    <= data_q[`DMD_F_C];
      sleep_q    <= data_q[`DMD_F_D];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Address pointer, shift offsets and increment tracking.
  dmd_pkg::dmd_char_addr_t ptr_char_q, off_char_q, next_char_q;
  dmd_pkg::dmd_sym_addr_t  ptr_sym_q, off_sym_q, next_sym_q;
  logic                    inc_char_q, inc_sym_q;
  wire                     rl       = data_q[`DMD_F_C];
  wire dmd_pkg::dmd_char_addr_t step_c = rl ? 6'(`DMD_CHAR_DEPTH - 1) : 6'd1;
  wire dmd_pkg::dmd_sym_addr_t  step_s = rl ? 4'(`DMD_SYM_DEPTH - 1) : 4'd1;
  wire dmd_pkg::dmd_char_addr_t wa_c   = (data_q[`DMD_F_M] & inc_char_q) ? next_char_q : add52(f_da, 6'd0);
  wire dmd_pkg::dmd_sym_addr_t  wa_s   = (data_q[`DMD_F_M] & inc_sym_q) ? next_sym_q : add13(f_ra, 4'd0);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ptr_char_q <= '0;
      ptr_sym_q  <= '0;
    end else if (do_ptr) begin
      ptr_char_q <= add52(f_da, 6'd0);  // [RULE23]
      ptr_sym_q  <= add13(f_ra_ptr, 4'd0);  // [RULE23]
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      off_char_q <= '0;
      off_sym_q  <= '0;
    end else if (do_shift) begin
      if (data_q[`DMD_F_M]) begin
        off_char_q <= add52(off_char_q, step_c);  // [RULE3] [RULE22]
      end
      if (data_q[`DMD_F_A]) begin
        off_sym_q <= add13(off_sym_q, step_s);  // [RULE6] [RULE22]
      end
    end
  end

  // A write with the flag set advances on from the previous write if that one was flagged too.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      inc_char_q  <= 1'b0;
      next_char_q <= '0;
      inc_sym_q   <= 1'b0;
      next_sym_q  <= '0;
    end else begin
      if (do_charw) begin
        inc_char_q  <= data_q[`DMD_F_M];  // [RULE24]
        next_char_q <= add52(wa_c, 6'd1);
      end
      if (do_symw) begin
        inc_sym_q  <= data_q[`DMD_F_M];  // [RULE25]
        next_sym_q <= add13(wa_s, 4'd1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Display memories.
  dmd_pkg::dmd_code_t char_ram_q [`DMD_CHAR_DEPTH];
  logic [4:0]         sym_ram_q  [`DMD_SYM_DEPTH];

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      for (int i = 0; i < `DMD_CHAR_DEPTH; i++) begin
        char_ram_q[i] <= `DMD_RST_CODE;  // [RULE1]
      end
    end else if (do_charw) begin
      char_ram_q[wa_c] <= data_q[`DMD_F_LO +: 8];  // [RULE1] [RULE24]
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      for (int i = 0; i < `DMD_SYM_DEPTH; i++) begin
        sym_ram_q[i] <= '0;
      end
    end else if (do_symw) begin
      sym_ram_q[wa_s] <= data_q[`DMD_F_LO +: 5];  // [RULE5] [RULE25]
    end
  end

  dmd_glyph_if gl ();

  assign gl.wr_en      = do_glyph & (data_q[`DMD_F_SLOT +: 8] < 8'(`DMD_GRAM_DEPTH));  // [RULE26]
  assign gl.wr_slot    = data_q[`DMD_F_SLOT +: 4];
  assign gl.wr_pattern = data_q[`DMD_PAT_BITS-1:0];  // [RULE26]

  dmd_glyph_lookup u_lookup (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .gl    (gl.lookup)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Digit scanner: one digit per clock, mapped through pointer and offset.
  logic [3:0]  dig_q;
  wire  [5:0]  dig6     = {2'b00, dig_q};
  wire  [5:0]  map_c    = add52(add52(ptr_char_q, off_char_q), dig6);  // [RULE2] [RULE3]
  wire  [3:0]  map_s    = add13(add13(ptr_sym_q, off_sym_q), dig_q);  // [RULE6]
  wire         dark     = blank_q | sleep_q;  // [RULE21]
  wire         dig_on   = digit_en_q[dig_q] & ~dark;
  wire         show_m   = dig_on & main_en_q;  // [RULE20]
  wire         show_a   = dig_on & sym_en_q;  // [RULE20]

  assign gl.rd_code = char_ram_q[map_c];  // [RULE8]

  always_ff @(posedge i_clk) begin
    if (i_rst || dig_q == 4'(`DMD_DIGITS - 1)) begin
      dig_q <= '0;
    end else begin
      dig_q <= dig_q + 4'd1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_scan_valid      <= 1'b0;
      o_scan_digit      <= '0;
      o_main_glyph_data <= '0;
      o_symbol_dot_data <= '0;
    end else begin
      o_scan_valid      <= 1'b1;
      o_scan_digit      <= dig_q + 4'd1;
      o_main_glyph_data <= show_m ? gl.rd_pattern : '0;  // [RULE8] [RULE20]
      o_symbol_dot_data <= show_a ? sym_ram_q[map_s] : 5'd0;  // [RULE5] [RULE20]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Oscillator model and frame timing; sleep stops the oscillator.
  logic [6:0]  osc_q;
  logic [11:0] frame_q;
  wire         osc_tick = (osc_q == 7'(`DMD_OSC_DIV - 1)) & ~sleep_q;
  wire  [11:0] base_div = (duty_q == 2'b00) ? 12'(`DMD_FRAME_DIV8) :
                          (duty_q == 2'b10) ? 12'(`DMD_FRAME_DIV9) : 12'(`DMD_FRAME_DIV10);  // [RULE18]
  wire  [11:0] frame_div = frc_q ? {1'b0, base_div[11:1]} : base_div;  // [RULE18]

  always_ff @(posedge i_clk) begin
    if (i_rst || osc_tick || sleep_q) begin
      osc_q <= '0;
    end else begin
      osc_q <= osc_q + 7'd1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      frame_q      <= '0;
      o_frame_tick <= 1'b0;
    end else begin
      o_frame_tick <= osc_tick && frame_q == frame_div - 12'd1;
      if (osc_tick) begin
        frame_q <= (frame_q >= frame_div - 12'd1) ? 12'd0 : frame_q + 12'd1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Contrast, ports and plain status outputs.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_contrast_level  <= '0;
      o_contrast_enable <= 1'b0;
    end else if (do_con) begin
      o_contrast_level  <= data_q[`DMD_F_ADDR +: 4];  // [RULE27]
      o_contrast_enable <= data_q[`DMD_F_M];  // [RULE27]
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_scan_line_setting <= '0;
      o_output_port_level <= '0;
      o_port_role_select  <= '0;
    end else if (do_port) begin
      o_scan_line_setting <= data_q[`DMD_F_ADDR +: 6];  // [RULE28]
      o_output_port_level <= data_q[`DMD_F_M +: 2];  // [RULE28]
      o_port_role_select  <= data_q[`DMD_F_C +: 2];  // [RULE28]
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_busy              <= 1'b0;
      o_sleep_select      <= 1'b0;
      o_duty_select       <= `DMD_RST_DUTY;
      o_frame_rate_select <= 1'b0;
      o_com9_en           <= 1'b0;
      o_com10_en          <= 1'b0;
      o_output_blank      <= 1'b0;
    end else begin
      o_busy              <= timed | (busy_q != 10'd0);  // [RULE14]
      o_sleep_select      <= sleep_q;
      o_duty_select       <= duty_q;
      o_frame_rate_select <= frc_q;
      o_com9_en           <= duty_q != 2'b00;  // [RULE17]
      o_com10_en          <= duty_q[0];  // [RULE17]
      o_output_blank      <= dark;  // [RULE21]
    end
  end

endmodule

// ===== hdl/dmd_defs.svh
// Constants of the dot matrix display command core: field positions, opcodes,
// memory sizes, reset values and timing counts.
// Assumes it is included once per compilation unit by its bare name.
`ifndef DMD_DEFS_SVH
`define DMD_DEFS_SVH

////////////////////////////////////////////////////////////////////////////////
// Timing.
`define DMD_CLK_HZ          25000000
`define DMD_CLK_PERIOD_NS   40
`define DMD_OSC_HZ          300000
`define DMD_EXEC_TIME_NS    27000
`define DMD_EXEC_CYC        ((`DMD_EXEC_TIME_NS + `DMD_CLK_PERIOD_NS - 1) / `DMD_CLK_PERIOD_NS)
`define DMD_OSC_DIV         (`DMD_CLK_HZ / `DMD_OSC_HZ)
`define DMD_FRAME_DIV8      3072
`define DMD_FRAME_DIV9      3456
`define DMD_FRAME_DIV10     3840

////////////////////////////////////////////////////////////////////////////////
// Sizes.
`define DMD_ADDR_BITS       8
`define DMD_DATA_BITS       64
`define DMD_CHAR_DEPTH      52
`define DMD_SYM_DEPTH       13
`define DMD_DIGITS          13
`define DMD_ROM_CODES       240
`define DMD_GRAM_DEPTH      16
`define DMD_PAT_BITS        45

////////////////////////////////////////////////////////////////////////////////
// Opcodes as the bit string D60 D61 D62 D63.
`define DMD_OP_TECH         4'b0001
`define DMD_OP_ONOFF        4'b0010
`define DMD_OP_SHIFT        4'b0011
`define DMD_OP_SETPTR       4'b0100
`define DMD_OP_CHARW        4'b0101
`define DMD_OP_SYMW         4'b0110
`define DMD_OP_GLYPHW       4'b0111
`define DMD_OP_CONTRAST     4'b1000
`define DMD_OP_PORT         4'b1001

////////////////////////////////////////////////////////////////////////////////
// Field positions inside the 64 instruction bits.
`define DMD_F_LO            40
`define DMD_F_ADDR          48
`define DMD_F_M             56
`define DMD_F_A             57
`define DMD_F_C             58
`define DMD_F_D             59
`define DMD_F_SLOT          48

////////////////////////////////////////////////////////////////////////////////
// Reset values.
`define DMD_RST_DUTY        2'b00
`define DMD_RST_DIGITS      13'h0000
`define DMD_RST_CODE        8'h00

`endif

// ===== hdl/dmd_glyph_if.sv
// Carries glyph lookups and glyph RAM writes between the core and the lookup.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps

interface dmd_glyph_if;
  dmd_pkg::dmd_code_t    rd_code;
  dmd_pkg::dmd_pattern_t rd_pattern;
  logic                  wr_en;
  logic [3:0]            wr_slot;
  dmd_pkg::dmd_pattern_t wr_pattern;
  modport core   (output rd_code, input rd_pattern, output wr_en, output wr_slot, output wr_pattern);
  modport lookup (input rd_code, output rd_pattern, input wr_en, input wr_slot, input wr_pattern);
endinterface

// ===== hdl/dmd_glyph_lookup.sv
// Glyph ROM and writable glyph RAM behind one combinational lookup port.
// Assumes writes arrive as single-cycle strobes on the core's clock.
`timescale 1ns/1ps
`include "dmd_defs.svh"

module dmd_glyph_lookup (
  // Clock and reset.
  input wire logic   i_clk,
  input wire logic   i_rst,
  // Lookup and write port.
  dmd_glyph_if.lookup gl
);

  dmd_pkg::dmd_pattern_t gram_q [`DMD_GRAM_DEPTH];
  wire                   use_ram;
  wire [3:0]             ram_slot;

  // Fixed font table; the dot contents are arbitrary, only the indexing matters.
  function automatic dmd_pkg::dmd_pattern_t rom_pattern(input dmd_pkg::dmd_code_t code);
    rom_pattern = {5{code, ^code}};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // The source is chosen from the code alone: codes below 16 are user glyphs.
  assign use_ram       = (gl.rd_code < 8'(`DMD_GRAM_DEPTH));  // [RULE10]
  assign ram_slot      = gl.rd_code[3:0];
  assign gl.rd_pattern = use_ram ? gram_q[ram_slot] : rom_pattern(gl.rd_code);  // [RULE8] [RULE10]

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      for (int i = 0; i < `DMD_GRAM_DEPTH; i++) begin
        gram_q[i] <= '0;
      end
    end else if (gl.wr_en) begin
      gram_q[gl.wr_slot] <= gl.wr_pattern;  // [RULE9]
    end
  end

endmodule

// ===== hdl/dmd_pkg.sv
// Types shared by the dot matrix display command core files.
// Assumes dmd_defs.svh is available on the include path.
`include "dmd_defs.svh"

package dmd_pkg;
  typedef logic [5:0]                    dmd_char_addr_t;
  typedef logic [3:0]                    dmd_sym_addr_t;
  typedef logic [7:0]                    dmd_code_t;
  typedef logic [`DMD_PAT_BITS-1:0]      dmd_pattern_t;
  typedef enum logic [1:0] {
    DMD_RX_ADDR,
    DMD_RX_DATA
  } dmd_rx_state_t;
endpackage

// ===== testbench/dmd_core_properties.sv
// Port-level checks of the command core's scan, duty and busy timing.
// Assumes a bind to every dmd_core instance and pins held stable near edges.
`timescale 1ns/1ps

module dmd_core_properties (
  input wire logic       i_clk,
  input wire logic       i_rst,
  input wire logic       i_chip_enable_pin,
  input wire logic       o_busy,
  input wire logic       o_sleep_select,
  input wire logic [1:0] o_duty_select,
  input wire logic       o_com9_en,
  input wire logic       o_com10_en,
  input wire logic       o_output_blank,
  input wire logic       o_scan_valid,
  input wire logic [3:0] o_scan_digit
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic       ce_q;
  logic [3:0] ce_cnt_q;
  logic [9:0] busy_cnt_q;
  // The fall counter saturates, so an old transfer never excuses a change.
  always_ff @(posedge i_clk) begin
    ce_q <= i_chip_enable_pin;
    if (i_rst) ce_cnt_q <= 4'hF;
    else if (ce_q && !i_chip_enable_pin) ce_cnt_q <= 4'h0;
    else if (ce_cnt_q != 4'hF) ce_cnt_q <= ce_cnt_q + 4'h1;
    if (i_rst || !o_busy) busy_cnt_q <= 10'h000;
    else busy_cnt_q <= busy_cnt_q + 10'h001;
  end
  sequence ce_recent;
    ce_cnt_q >= 4'h1 && ce_cnt_q <= 4'h8;
  endsequence
  sequence busy_run;
    o_busy [*8];
  endsequence
  digit_wrap_a: assert property (o_scan_valid && o_scan_digit == 4'hD |=> o_scan_digit == 4'h1)
    else $error("scan digit did not wrap");
  digit_step_a: assert property (o_scan_valid && o_scan_digit != 4'hD |=> o_scan_digit == $past(o_scan_digit) + 4'h1)
    else $error("scan digit did not step");
  com9_map_a: assert property (o_com9_en == (o_duty_select != 2'b00))
    else $error("common 9 enable wrong");
  com10_map_a: assert property (o_com10_en == o_duty_select[0])
    else $error("common 10 enable wrong");
  busy_len_a: assert property ($fell(o_busy) |-> busy_cnt_q == 10'h2A3)
    else $error("busy window length wrong");
  busy_start_a: assert property ($rose(o_busy) |-> ce_recent ##0 busy_run)
    else $error("busy rose without enable fall");
  duty_after_ce_a: assert property (!$stable(o_duty_select) |-> ce_recent)
    else $error("duty changed without enable fall");
  sleep_blank_a: assert property (o_sleep_select |-> o_output_blank)
    else $error("sleep without blanked outputs");
endmodule

bind dmd_core dmd_core_properties u_props (.i_clk, .i_rst, .i_chip_enable_pin, .o_busy, .o_sleep_select,
  .o_duty_select, .o_com9_en, .o_com10_en, .o_output_blank, .o_scan_valid, .o_scan_digit);

// ===== testbench/dmd_host_model.sv
// Host model that shifts address and instruction bits into the serial pins.
// Assumes the caller waits out the execution time between transfers.
`timescale 1ns/1ps

module dmd_host_model (
  // Serial pins.
  output logic o_cl = 1'b0,
  output logic o_sd = 1'b0,
  output logic o_ce = 1'b0
);
  task automatic put(input logic v);
    o_cl = 1'b0;
    o_sd = v;
    #160 o_cl = 1'b1;
    #160;
  endtask
  // Address then 64 bits, each field least significant bit first, the opcode most significant bit first.
  task automatic send(input logic [7:0] a, input logic [63:0] d, input logic idle);
    o_cl = idle;
    #320;
    for (int i = 0; i < 8; i++) put(a[i]);
    o_ce = 1'b1;
    #160;
    for (int i = 0; i < 64; i++) put(d[i]);
    o_cl = idle;
    #160 o_ce = 1'b0;
    // A released data line must not keep the last bit, so it toggles.
    #160 o_sd = ~o_sd;
  endtask
endmodule

// ===== testbench/tb.sv
// Self-checking bench for the command core driven through the host model.
// Assumes the package, header and design files are compiled first.
`timescale 1ns/1ps
`include "dmd_defs.svh"

module tb;
  localparam logic [7:0] BA = 8'h5A;
  logic        i_clk = 1'b0, i_rst = 1'b1, i_shift_clock_pin, i_serial_data_pin, i_chip_enable_pin, bz;
  logic        o_busy, o_sleep_select, o_frame_rate_select, o_com9_en, o_com10_en, o_frame_tick;
  logic        o_output_blank, o_contrast_enable, o_scan_valid;
  logic [1:0]  o_duty_select, o_output_port_level, o_port_role_select;
  logic [3:0]  o_contrast_level, o_scan_digit;
  logic [5:0]  o_scan_line_setting;
  logic [44:0] o_main_glyph_data;
  logic [4:0]  o_symbol_dot_data;
  int          n_fail = 0;
  int          checks = 0;
  localparam logic [44:0] GP = 45'h0A2B_3C4D_5E6F;
  always #20 i_clk = ~i_clk;
  dmd_host_model u_host (.o_cl(i_shift_clock_pin), .o_sd(i_serial_data_pin), .o_ce(i_chip_enable_pin));
  dmd_core #(.BUS_ADDR(BA)) u_dut (.i_clk, .i_rst, .i_shift_clock_pin, .i_serial_data_pin, .i_chip_enable_pin,
    .o_busy, .o_sleep_select, .o_duty_select, .o_frame_rate_select, .o_com9_en, .o_com10_en, .o_frame_tick,
    .o_output_blank, .o_contrast_level, .o_contrast_enable, .o_scan_line_setting, .o_output_port_level,
    .o_port_role_select, .o_scan_valid, .o_scan_digit, .o_main_glyph_data, .o_symbol_dot_data);
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] s);
    checks++;
    if (s !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, s);
      n_fail++;
    end
  endtask
  function automatic logic [63:0] ins(input logic [3:0] op, input logic [19:0] f);
    return {op[0], op[1], op[2], op[3], f, 40'h0};
  endfunction
  function automatic logic [44:0] pat(input logic [7:0] c);
    return {5{c, ^c}};
  endfunction
  // Busy is sampled once the result has landed, then waited out with margin.
  task automatic tx(input logic [63:0] d, input logic idle = 1'b0, input logic [7:0] a = BA);
    u_host.send(a, d, idle);
    repeat (8) @(posedge i_clk);
    #2 bz = o_busy;
    for (int k = 0; o_busy !== 1'b0; k++) begin
      if (k > 800) begin
        n_fail++;
        summarize();
      end
      @(posedge i_clk);
    end
    repeat (20) @(posedge i_clk);
    #2;
  endtask
  task automatic at_digit(input logic [3:0] n, input logic [44:0] em, input logic [4:0] es);
    for (int k = 0; o_scan_digit !== n; k++) begin
      if (k > 20) begin
        n_fail++;
        summarize();
      end
      @(posedge i_clk);
      #2;
    end
    chk("glyph", em, o_main_glyph_data);
    chk("dots", es, o_symbol_dot_data);
  endtask
  task automatic t_duty();
    logic [1:0] ds [3] = '{2'b00, 2'b10, 2'b01};
    for (int i = 0; i < 6; i++) begin
      tx(ins(`DMD_OP_TECH, {1'b0, i[0], ds[i/2][0], ds[i/2][1], 16'h0}), i[0]);
      chk("tech", {ds[i/2], i[0], ds[i/2] != 2'b00, ds[i/2][0], 1'b0},
          {o_duty_select, o_frame_rate_select, o_com9_en, o_com10_en, bz});
    end
  endtask
  task automatic t_refuse();
    tx(ins(`DMD_OP_TECH, {4'h1, 16'h0}), 1'b0, BA ^ 8'h01);
    chk("duty", 2'b01, o_duty_select);
  endtask
  task automatic t_show();
    tx(ins(`DMD_OP_GLYPHW, {4'h0, 8'h03, 8'h0}) | 64'(GP));
    tx(ins(`DMD_OP_CHARW, {6'h0, 6'h00, 8'h41}));
    chk("busy", 1'b1, bz);
    tx(ins(`DMD_OP_CHARW, {6'h0, 6'h01, 8'h03}));
    tx(ins(`DMD_OP_CHARW, {6'h0, 6'h33, 8'h7E}));
    tx(ins(`DMD_OP_SYMW, {8'h0, 4'h0, 3'h0, 5'h15}));
    tx(ins(`DMD_OP_SYMW, {8'h0, 4'h1, 3'h0, 5'h0A}));
    tx(ins(`DMD_OP_SYMW, {8'h0, 4'hC, 3'h0, 5'h1F}));
    tx(ins(`DMD_OP_ONOFF, {4'h3, 3'h0, 13'h1FFF}));
    at_digit(4'h1, pat(8'h41), 5'h15);
    at_digit(4'h2, GP, 5'h0A);
    at_digit(4'hD, 45'h0, 5'h1F);
    tx(ins(`DMD_OP_SHIFT, {4'h7, 16'h0}));
    at_digit(4'h1, pat(8'h7E), 5'h1F);
    at_digit(4'h2, pat(8'h41), 5'h15);
    tx(ins(`DMD_OP_SHIFT, {4'h3, 16'h0}));
    tx(ins(`DMD_OP_SHIFT, {4'h3, 16'h0}));
    at_digit(4'h1, GP, 5'h0A);
    at_digit(4'hD, 45'h0, 5'h15);
    tx(ins(`DMD_OP_ONOFF, {4'h1, 3'h0, 13'h0001}));
    at_digit(4'h1, GP, 5'h00);
    at_digit(4'h2, 45'h0, 5'h00);
    tx(ins(`DMD_OP_ONOFF, {4'h7, 3'h0, 13'h1FFF}));
    chk("blank", 1'b1, o_output_blank);
    tx(ins(`DMD_OP_ONOFF, {4'hB, 3'h0, 13'h1FFF}));
    chk("sleep", 2'b11, {o_sleep_select, bz});
    tx(ins(`DMD_OP_ONOFF, {4'h3, 3'h0, 13'h1FFF}));
    chk("wake", 3'b000, {o_sleep_select, o_output_blank, bz});
    tx(ins(`DMD_OP_CHARW, {3'h0, 1'b1, 2'h0, 6'h05, 8'h41}));
    tx(ins(`DMD_OP_CHARW, {3'h0, 1'b1, 2'h0, 6'h20, 8'h7E}));
    tx(ins(`DMD_OP_SETPTR, {4'hB, 2'h0, 6'h04, 8'h0}));
    at_digit(4'h1, pat(8'h41), 5'h1F);
    at_digit(4'h2, pat(8'h7E), 5'h15);
  endtask
  task automatic t_ports();
    tx(ins(`DMD_OP_CONTRAST, {3'h0, 1'b1, 4'h0, 4'h9, 8'h0}));
    chk("contrast", 5'h19, {o_contrast_enable, o_contrast_level});
    tx(ins(`DMD_OP_PORT, {4'h6, 2'h0, 6'h2B, 8'h0}));
    chk("port", 10'h26B, {o_output_port_level, o_port_role_select, o_scan_line_setting});
  endtask
  initial begin
    repeat (4) @(posedge i_clk);
    #2 i_rst = 1'b0;
    repeat (3) @(posedge i_clk);
    t_duty();
    t_refuse();
    t_show();
    t_ports();
    summarize();
  end
endmodule
